// File: rtl/iri_pkg.sv
// shared constants and types for interrupt routing and pin indication
package iri_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ROUTE = 8'h71;
	localparam logic [7:0] ADDR_STYLE = 8'h72;
	localparam logic [7:0] ADDR_STAT_A = 8'h77;
	localparam logic [7:0] ADDR_STAT_B = 8'h78;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ROUTE_W = 3;
	localparam int unsigned DSP3_LSB = 4;
	localparam int unsigned DSP4_LSB = 0;
	localparam logic [7:0] ROUTE_MASK = 8'h77;
	localparam logic [7:0] ROUTE_RST = 8'h00;
	localparam logic [2:0] ROUTE_NONE = 3'h0;
	localparam int unsigned STYLE_W = 2;
	localparam int unsigned STYLE_PIN1_LSB = 6;
	localparam logic [7:0] STYLE_RST = 8'h00;
	localparam int unsigned NUM_PINS = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_MHZ = 200;
	localparam int unsigned PULSE_TIME_US = 2000;
	localparam int unsigned PERIOD_TIME_US = 4000;
	localparam int unsigned PULSE_CYC = PULSE_TIME_US * CLK_FREQ_MHZ;
	localparam int unsigned PERIOD_CYC = PERIOD_TIME_US * CLK_FREQ_MHZ;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		IRI_STYLE_ONE_SHOT = 2'h0,
		IRI_STYLE_REPEAT = 2'h1,
		IRI_STYLE_LEVEL = 2'h2,
		IRI_STYLE_LIVE = 2'h3
	} iri_style_e;

	typedef enum logic [1:0] {
		IRI_PH_IDLE = 2'b00,
		IRI_PH_HIGH = 2'b01,
		IRI_PH_LOW = 2'b11
	} iri_phase_e;

	// ----------------------------------------------------------------
	// register access request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iri_req_s;

endpackage

// File: rtl/iri_pin_indicator.sv
// one interrupt pin: pulse, repeated pulse, level or live indication
`timescale 1ns/1ps
module iri_pin_indicator #(
	parameter int unsigned PULSE_CYC = iri_pkg::PULSE_CYC,
	parameter int unsigned PERIOD_CYC = iri_pkg::PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [1:0] style_i,
	input wire logic live_i,
	input wire logic event_i,
	input wire logic held_i,
	output logic pin_o
);

	localparam int unsigned CW = $clog2(PERIOD_CYC + 1);
	localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);
	localparam logic [CW-1:0] GAP_LAST = CW'(PERIOD_CYC - PULSE_CYC - 1);

	typedef struct packed {
		iri_pkg::iri_phase_e phase;
		logic [CW-1:0] cnt;
		logic pin;
	} iri_ind_s;

	iri_ind_s q;
	iri_ind_s next_q;
	logic start;

	// ----------------------------------------------------------------
	// pulse timer
	// ----------------------------------------------------------------
	// one shot fires on a fresh edge; repeat restarts while status held
	always_comb begin
		next_q = q;
		start = (style_i == iri_pkg::IRI_STYLE_ONE_SHOT && event_i) ||
			(style_i == iri_pkg::IRI_STYLE_REPEAT && held_i);
		case (q.phase)
			iri_pkg::IRI_PH_IDLE: begin
				if (start) begin
					next_q.phase = iri_pkg::IRI_PH_HIGH; // RULE_06
					next_q.cnt = '0;
				end
			end
			iri_pkg::IRI_PH_HIGH: begin
				if (q.cnt == PULSE_LAST) begin // RULE_12
					next_q.cnt = '0;
					next_q.phase = (style_i == iri_pkg::IRI_STYLE_REPEAT) ?
						iri_pkg::IRI_PH_LOW : iri_pkg::IRI_PH_IDLE;
				end else begin
					next_q.cnt = q.cnt + 1'b1;
				end
			end
			iri_pkg::IRI_PH_LOW: begin
				if (q.cnt == GAP_LAST) begin // RULE_07
					next_q.cnt = '0;
					next_q.phase = held_i ? iri_pkg::IRI_PH_HIGH : iri_pkg::IRI_PH_IDLE;
				end else begin
					next_q.cnt = q.cnt + 1'b1;
				end
			end
			default: begin
				next_q.phase = iri_pkg::IRI_PH_IDLE;
				next_q.cnt = '0;
			end
		endcase
		// leaving a pulsed style drops any pulse in flight
		if (style_i == iri_pkg::IRI_STYLE_LEVEL || style_i == iri_pkg::IRI_STYLE_LIVE) begin
			next_q.phase = iri_pkg::IRI_PH_IDLE;
			next_q.cnt = '0;
		end
		if (style_i == iri_pkg::IRI_STYLE_LEVEL) begin
			next_q.pin = held_i; // RULE_08
		end else if (style_i == iri_pkg::IRI_STYLE_LIVE) begin
			next_q.pin = live_i; // RULE_09
		end else begin
			next_q.pin = (next_q.phase == iri_pkg::IRI_PH_HIGH);
		end
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{phase: iri_pkg::IRI_PH_IDLE, cnt: '0, pin: 1'b0};
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	assign pin_o = q.pin;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	pulse_width_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_06
		(q.phase == iri_pkg::IRI_PH_HIGH) |-> (q.cnt <= PULSE_LAST && q.pin))
		else $error("pulse counter beyond pulse width");
	pulse_end_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_12
		(q.phase == iri_pkg::IRI_PH_HIGH && q.cnt == PULSE_LAST &&
		style_i == iri_pkg::IRI_STYLE_ONE_SHOT) |=> (!q.pin && q.phase == iri_pkg::IRI_PH_IDLE))
		else $error("one shot pulse did not end on time");
	repeat_again_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_07
		(q.phase == iri_pkg::IRI_PH_LOW && q.cnt == GAP_LAST && held_i &&
		style_i == iri_pkg::IRI_STYLE_REPEAT) |=> (q.pin && q.cnt == '0))
		else $error("repeat pulse did not restart after gap");
	shot_start_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_06
		(q.phase == iri_pkg::IRI_PH_IDLE && event_i &&
		style_i == iri_pkg::IRI_STYLE_ONE_SHOT) |=> q.pin)
		else $error("one shot pulse not started");

endmodule

// File: rtl/iri_route_top.sv
// interrupt routing registers, sticky status and four indication pins
//
// Overview of operation
// [RULE_01] dsp interrupt three goes to the pin chosen by route bits 6:4, 0 meaning no pin, reset 0.
// [RULE_02] dsp interrupt four goes to the pin chosen by route bits 2:0, 0 meaning no pin, reset 0.
// [RULE_03] the host never writes route codes 5 to 7, which reach no pin here.
// [RULE_04] pin one style sits in bits 7:6 and pin two style in bits 5:4, both reset 0.
// [RULE_05] pin three style sits in bits 3:2 and pin four style in bits 1:0, both reset 0.
// [RULE_06] style 0 gives one 2 ms high pulse per interrupt.
// [RULE_07] style 1 repeats 2 ms high pulses every 4 ms until the status is read clear.
// [RULE_08] style 2 holds the pin high until the status is read clear.
// [RULE_09] style 3 copies the live combined interrupt value onto the pin.
// [RULE_10] every source uses the same three bit route encoding in its own field.
// [RULE_11] routed sources set sticky bits, each pin ORs its sources, and a read clears the bits.
// [RULE_12] pulse width and period come from cycle counters on the block clock.
`timescale 1ns/1ps
module iri_route_top #(
	parameter int unsigned PULSE_CYC = iri_pkg::PULSE_CYC,
	parameter int unsigned PERIOD_CYC = iri_pkg::PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire iri_pkg::iri_req_s req_i,
	input wire logic dsp_irq3_i,
	input wire logic dsp_irq4_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic irq_pin_one_o,
	output logic irq_pin_two_o,
	output logic irq_pin_three_o,
	output logic irq_pin_four_o
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PULSE_CYC < 1 || PERIOD_CYC <= PULSE_CYC) begin : g_bad_timing
		$error("pulse must be at least one cycle and shorter than the period");
	end

	typedef struct packed {
		logic [7:0] route;
		logic [7:0] style;
		logic sticky_a;
		logic sticky_b;
		logic [iri_pkg::NUM_PINS-1:0] live_q;
		logic [7:0] rdata;
		logic rvalid;
	} iri_top_s;

	iri_top_s q;
	iri_top_s next_q;
	logic [2:0] sel3;
	logic [2:0] sel4;
	logic [iri_pkg::NUM_PINS-1:0] live;
	logic [iri_pkg::NUM_PINS-1:0] held;
	logic [iri_pkg::NUM_PINS-1:0] pins;
	logic routed3;
	logic routed4;
	logic rd_a;
	logic rd_b;

	// ----------------------------------------------------------------
	// routing decode
	// ----------------------------------------------------------------
	// shared by every source field; reserved codes match no pin
	function automatic logic route_hits(input logic [2:0] sel, input logic [2:0] code);
		route_hits = (sel == code); // RULE_10
	endfunction

	function automatic logic route_valid(input logic [2:0] sel);
		route_valid = (sel != iri_pkg::ROUTE_NONE) && (sel <= 3'(iri_pkg::NUM_PINS)); // RULE_03
	endfunction

	// field extraction
	assign sel3 = q.route[iri_pkg::DSP3_LSB +: iri_pkg::ROUTE_W]; // RULE_01
	assign sel4 = q.route[iri_pkg::DSP4_LSB +: iri_pkg::ROUTE_W]; // RULE_02
	assign routed3 = route_valid(sel3);
	assign routed4 = route_valid(sel4);

	// per pin: combined live value, held status, indicator instance
	for (genvar p = 0; p < iri_pkg::NUM_PINS; p++) begin : g_pin
		localparam int unsigned STYLE_LSB = iri_pkg::STYLE_PIN1_LSB - iri_pkg::STYLE_W * p;
		localparam logic [2:0] CODE = 3'(p + 1);
		// live OR of every source steered here
		assign live[p] = (dsp_irq3_i && route_hits(sel3, CODE)) || // RULE_11
			(dsp_irq4_i && route_hits(sel4, CODE));
		assign held[p] = (q.sticky_a && route_hits(sel3, CODE)) ||
			(q.sticky_b && route_hits(sel4, CODE));
		iri_pin_indicator #(
			.PULSE_CYC(PULSE_CYC),
			.PERIOD_CYC(PERIOD_CYC)
		) u_ind (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.style_i(q.style[STYLE_LSB +: iri_pkg::STYLE_W]), // RULE_04 RULE_05
			.live_i(live[p]),
			.event_i(live[p] && !q.live_q[p]),
			.held_i(held[p]),
			.pin_o(pins[p])
		);
	end

	// ----------------------------------------------------------------
	// register access and sticky status
	// ----------------------------------------------------------------
	assign rd_a = req_i.rd && (req_i.addr == iri_pkg::ADDR_STAT_A);
	assign rd_b = req_i.rd && (req_i.addr == iri_pkg::ADDR_STAT_B);

	// a source asserting in the clearing read cycle wins, so no event is lost
	always_comb begin
		next_q = q;
		next_q.rvalid = 1'b0;
		if (req_i.wr) begin
			if (req_i.addr == iri_pkg::ADDR_ROUTE) begin
				next_q.route = req_i.wdata & iri_pkg::ROUTE_MASK; // RULE_01 RULE_02
			end else if (req_i.addr == iri_pkg::ADDR_STYLE) begin
				next_q.style = req_i.wdata; // RULE_04 RULE_05
			end
		end
		if (req_i.rd) begin
			next_q.rvalid = 1'b1;
			if (req_i.addr == iri_pkg::ADDR_ROUTE) begin
				next_q.rdata = q.route;
			end else if (req_i.addr == iri_pkg::ADDR_STYLE) begin
				next_q.rdata = q.style;
			end else if (req_i.addr == iri_pkg::ADDR_STAT_A) begin
				next_q.rdata = {7'h00, q.sticky_a};
			end else if (req_i.addr == iri_pkg::ADDR_STAT_B) begin
				next_q.rdata = {7'h00, q.sticky_b};
			end else begin
				next_q.rdata = 8'h00;
			end
		end
		next_q.sticky_a = (q.sticky_a && !rd_a) || (dsp_irq3_i && routed3); // RULE_11
		next_q.sticky_b = (q.sticky_b && !rd_b) || (dsp_irq4_i && routed4); // RULE_11
		next_q.live_q = live;
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '{route: iri_pkg::ROUTE_RST, style: iri_pkg::STYLE_RST, sticky_a: 1'b0,
				sticky_b: 1'b0, live_q: '0, rdata: 8'h00, rvalid: 1'b0};
		end else if (ce_i) begin
			q <= next_q;
		end
	end

	// outputs, all from flip-flops
	assign rdata_o = q.rdata;
	assign rvalid_o = q.rvalid;
	assign irq_pin_one_o = pins[0];
	assign irq_pin_two_o = pins[1];
	assign irq_pin_three_o = pins[2];
	assign irq_pin_four_o = pins[3];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	route_write_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_01
		(req_i.wr && req_i.addr == iri_pkg::ADDR_ROUTE) |=>
		(q.route == ($past(req_i.wdata) & 8'h77)))
		else $error("route register did not take the write");
	dsp3_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
		(sel3 == 3'h4 && dsp_irq3_i) |-> live[3])
		else $error("dsp three not routed to pin four");
	dsp4_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
		(sel4 == 3'h2 && dsp_irq4_i) |-> (live[1] && !live[0]))
		else $error("dsp four not routed to pin two alone");
	reserved_none_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
		(sel3 > 3'h4 && sel4 == 3'h0) |-> (live == 4'h0 && held == 4'h0))
		else $error("reserved route code reached a pin");
	sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_11
		(dsp_irq3_i && routed3) |=> q.sticky_a)
		else $error("sticky bit missed a routed source");
	read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_11
		(rd_b && !(dsp_irq4_i && routed4)) |=> (!q.sticky_b && q.rvalid))
		else $error("status read did not clear sticky bit");
	live_copy_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_09
		(q.style[7:6] == 2'h3) |=> (irq_pin_one_o == $past(live[0])))
		else $error("live style pin does not follow interrupt");
	level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_08
		(q.style[5:4] == 2'h2) |=> (irq_pin_two_o == $past(held[1])))
		else $error("level style pin does not follow status");

	// register side: writes land at the taken edge, reads return the value before it
	style_write_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_04
		(req_i.wr && req_i.addr == iri_pkg::ADDR_STYLE) |=> (q.style == $past(req_i.wdata)))
		else $error("style register did not take the write");
	style_read_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_05
		(req_i.rd && req_i.addr == iri_pkg::ADDR_STYLE) |=> (rdata_o == $past(q.style)))
		else $error("style readback wrong");
	route_read_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_02
		(req_i.rd && req_i.addr == iri_pkg::ADDR_ROUTE) |=>
		(rdata_o == $past(q.route)))
		else $error("route readback wrong");
	status_read_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_11
		rd_a |=>
		(rdata_o == {7'h00, $past(q.sticky_a)}))
		else $error("status readback wrong");
	rvalid_idle_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_04
		(!req_i.rd) |=> !rvalid_o)
		else $error("read valid without a read");
	// sticky side: set by a routed source, cleared by its own read; then unrouted sources reach no pin
	sticky_b_set_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_11
		(dsp_irq4_i && routed4) |=> q.sticky_b)
		else $error("sticky bit b missed a routed source");
	clear_a_read_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // RULE_11
		(rd_a && !(dsp_irq3_i && routed3)) |=> !q.sticky_a)
		else $error("status read did not clear sticky bit a");
	route_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
		(!routed3 && !routed4) |-> (live == 4'h0))
		else $error("unrouted source reached a pin");
	// the whole register struct holds while ce_i is low; a dropped edge is better than a half step
	ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
		(!ce_i) |=> (q == $past(q)))
		else $error("state moved while clock enable low");

endmodule

// File: testbench/iri_host_model.sv
// host-side monitor of the four interrupt pins
`timescale 1ns/1ps
module iri_host_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic [3:0] pins_i,
	output logic [3:0][15:0] rise_cnt_o,
	output logic [3:0][15:0] hi_cnt_o
);
	logic [3:0] last;
	// pins sampled like a host gpio; clr_i restarts both tallies
	always_ff @(posedge clk_i) begin
		last <= pins_i;
		for (int i = 0; i < 4; i++) begin
			if (clr_i) begin
				rise_cnt_o[i] <= 16'h0000;
				hi_cnt_o[i] <= 16'h0000;
			end else begin
				rise_cnt_o[i] <= rise_cnt_o[i] + {15'h0000, pins_i[i] & ~last[i]};
				hi_cnt_o[i] <= hi_cnt_o[i] + {15'h0000, pins_i[i]};
			end
		end
	end
endmodule

// File: testbench/tb.sv
// self-checking bench for interrupt routing and pin indication
`timescale 1ns/1ps
module tb;
	// short counts keep pulse scenarios a few dozen cycles long
	localparam int unsigned PULSE = 4;
	localparam int unsigned PERIOD = 10;
	logic clk_i;
	logic rst_i;
	logic ce_i;
	iri_pkg::iri_req_s req_i;
	logic dsp_irq3_i;
	logic dsp_irq4_i;
	logic [7:0] rdata_o;
	logic rvalid_o;
	logic [3:0] pins;
	logic clr;
	logic [3:0][15:0] rise_cnt;
	logic [3:0][15:0] hi_cnt;
	int n_errors = 0;
	int check_count = 0;

	iri_route_top #(.PULSE_CYC(PULSE), .PERIOD_CYC(PERIOD)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .dsp_irq3_i(dsp_irq3_i),
		.dsp_irq4_i(dsp_irq4_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_pin_one_o(pins[0]),
		.irq_pin_two_o(pins[1]), .irq_pin_three_o(pins[2]), .irq_pin_four_o(pins[3]));

	iri_host_model host_u (.clk_i(clk_i), .clr_i(clr), .pins_i(pins), .rise_cnt_o(rise_cnt), .hi_cnt_o(hi_cnt));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// a lead-in edge keeps two strobes from landing in one time step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk_i);
		req_i <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(negedge clk_i);
		req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_i);
		req_i <= '0;
		chk("rvalid", 16'h0001, {15'h0000, rvalid_o});
		chk(name, {8'h00, exp}, {8'h00, rdata_o});
	endtask

	task automatic clear_mon();
		@(negedge clk_i);
		clr <= 1'b1;
		@(negedge clk_i);
		clr <= 1'b0;
	endtask

	task automatic pulse_src(input bit four, input int n);
		if (four) dsp_irq4_i <= 1'b1;
		else dsp_irq3_i <= 1'b1;
		cyc(n);
		dsp_irq3_i <= 1'b0;
		dsp_irq4_i <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_regs();
		rd(iri_pkg::ADDR_ROUTE, 8'h00, "route reset");
		rd(iri_pkg::ADDR_STYLE, 8'h00, "style reset");
		chk("pins after reset", 16'h0000, {12'h000, pins});
		wr(iri_pkg::ADDR_ROUTE, 8'hcc);
		rd(iri_pkg::ADDR_ROUTE, 8'h44, "route fields");
		wr(iri_pkg::ADDR_STYLE, 8'he4);
		rd(iri_pkg::ADDR_STYLE, 8'he4, "style fields");
		wr(8'h73, 8'h5a);
		rd(8'h73, 8'h00, "unmapped");
		wr(iri_pkg::ADDR_STAT_A, 8'h01);
		rd(iri_pkg::ADDR_STAT_A, 8'h00, "status read only");
	endtask

	// source held longer than the pulse: no retrigger, exact width
	task automatic sc_one_shot();
		wr(iri_pkg::ADDR_STYLE, 8'h00);
		wr(iri_pkg::ADDR_ROUTE, 8'h10);
		clear_mon();
		pulse_src(1'b0, PULSE + 2);
		cyc(PULSE + 4);
		chk("one-shot width", 16'(PULSE), hi_cnt[0]);
		chk("one-shot count", 16'h0001, rise_cnt[0]);
		chk("unrouted pins", 16'h0000, hi_cnt[1] | hi_cnt[2] | hi_cnt[3]);
		rd(iri_pkg::ADDR_STAT_A, 8'h01, "sticky a set");
		rd(iri_pkg::ADDR_STAT_A, 8'h00, "sticky a clear");
	endtask

	task automatic sc_level();
		wr(iri_pkg::ADDR_ROUTE, 8'h02);
		wr(iri_pkg::ADDR_STYLE, 8'h20);
		pulse_src(1'b1, 1);
		cyc(3 * PERIOD);
		chk("level held", 16'h0001, {15'h0000, pins[1]});
		rd(iri_pkg::ADDR_STAT_B, 8'h01, "sticky b set");
		cyc(3);
		chk("level released", 16'h0000, {15'h0000, pins[1]});
	endtask

	task automatic sc_repeat();
		wr(iri_pkg::ADDR_ROUTE, 8'h30);
		wr(iri_pkg::ADDR_STYLE, 8'h04);
		clear_mon();
		pulse_src(1'b0, 1);
		cyc(2 * PERIOD + 5);
		chk("repeat pulses", 16'h0003, rise_cnt[2]);
		rd(iri_pkg::ADDR_STAT_A, 8'h01, "sticky a repeat");
		cyc(2 * PERIOD);
		chk("repeat stopped", 16'h0003, rise_cnt[2]);
		chk("repeat high time", 16'(3 * PULSE), hi_cnt[2]);
	endtask

	// live copy follows the OR of both sources one cycle late
	task automatic sc_live();
		wr(iri_pkg::ADDR_ROUTE, 8'h44);
		wr(iri_pkg::ADDR_STYLE, 8'h03);
		for (int s = 0; s < 2; s++) begin
			pulse_src(s[0], 1);
			chk("live high", 16'h0001, {15'h0000, pins[3]});
			cyc(1);
			chk("live low", 16'h0000, {15'h0000, pins[3]});
		end
		wr(iri_pkg::ADDR_ROUTE, 8'h00);
		pulse_src(1'b1, 3);
		chk("route none", 16'h0000, {15'h0000, pins[3]});
	endtask

	// frozen clock enable must drop writes and source events alike
	task automatic sc_freeze();
		rd(iri_pkg::ADDR_STAT_A, 8'h01, "sticky a live");
		rd(iri_pkg::ADDR_STAT_B, 8'h01, "sticky b live");
		wr(iri_pkg::ADDR_ROUTE, 8'h01);
		wr(iri_pkg::ADDR_STYLE, 8'hc0);
		cyc(1);
		ce_i <= 1'b0;
		wr(iri_pkg::ADDR_ROUTE, 8'h00);
		pulse_src(1'b1, 2);
		chk("frozen pin", 16'h0000, {15'h0000, pins[0]});
		ce_i <= 1'b1;
		rd(iri_pkg::ADDR_ROUTE, 8'h01, "frozen write");
		rd(iri_pkg::ADDR_STAT_B, 8'h00, "frozen sticky");
		pulse_src(1'b1, 1);
		chk("thawed pin", 16'h0001, {15'h0000, pins[0]});
	endtask

	// mid-run reset returns registers, status and pins to idle
	task automatic sc_reset();
		wr(iri_pkg::ADDR_ROUTE, 8'h10);
		wr(iri_pkg::ADDR_STYLE, 8'h80);
		pulse_src(1'b0, 1);
		cyc(2);
		chk("level before reset", 16'h0001, {15'h0000, pins[0]});
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		chk("pins in reset", 16'h0000, {12'h000, pins});
		rd(iri_pkg::ADDR_ROUTE, 8'h00, "route after reset");
		rd(iri_pkg::ADDR_STYLE, 8'h00, "style after reset");
		rd(iri_pkg::ADDR_STAT_A, 8'h00, "sticky after reset");
	endtask

	// ------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		req_i = '0;
		dsp_irq3_i = 1'b0;
		dsp_irq4_i = 1'b0;
		clr = 1'b1;
		cyc(16);
		rst_i <= 1'b0;
		clr <= 1'b0;
		sc_regs();
		sc_one_shot();
		sc_level();
		sc_repeat();
		sc_live();
		sc_freeze();
		sc_reset();
		test_done();
	end
endmodule
